//--- rtl/ffdc_pkg.sv
// constants for the frame fetch dma control block
package ffdc_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] FFDC_CTRL_OFS   = 5'h00;  // frame_fetch_dma_control
    localparam logic [4:0] FFDC_A_BASE_OFS = 5'h04;  // buffer_a start address
    localparam logic [4:0] FFDC_A_CEIL_OFS = 5'h08;  // buffer_a ending address
    localparam logic [4:0] FFDC_B_BASE_OFS = 5'h0C;  // buffer_b start address
    localparam logic [4:0] FFDC_B_CEIL_OFS = 5'h10;  // buffer_b ending address
    localparam logic [4:0] FFDC_STAT_OFS   = 5'h14;  // sticky frame-end status
    localparam logic [4:0] FFDC_MASK_OFS   = 5'h18;  // frame-end mask
    localparam logic [4:0] FFDC_RUN_OFS    = 5'h1C;  // fetch run enable
    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int FFDC_MODE_BIT  = 0;   // double buffer mode
    localparam int FFDC_SWAP_BIT  = 1;   // byte_swap_enable
    localparam int FFDC_IRQEN_BIT = 2;   // frame_end_irq_enable
    localparam int FFDC_BURST_LO  = 4;   // burst code, bits 6-4
    localparam int FFDC_THR_LO    = 8;   // fifo_start_threshold, bits 10-8
    localparam logic [31:0] FFDC_CTRL_WMASK = 32'h0000_0777;  // writable bits
    localparam logic [31:0] FFDC_CTRL_RST   = 32'h0000_0000;  // reset value
    localparam logic [31:0] FFDC_ADDR_MASK  = 32'hFFFF_FFFC;  // low two bits zero
    // ------------------------------------------------------------
    // fifo and word sizes
    // ------------------------------------------------------------
    localparam int         FFDC_DEPTH    = 512;     // input fifo words
    localparam int         FFDC_PTR_W    = 9;       // pointer width
    localparam logic [9:0] FFDC_DEPTH_C  = 10'h200; // depth at count width
    localparam logic [1:0] FFDC_SIZE_WORD = 2'h2;   // 4-byte transfer code
    localparam logic [31:0] FFDC_WORD_BYTES = 32'h0000_0004;
    // ------------------------------------------------------------
    // fetch sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FFDC_IDLE, FFDC_REQ, FFDC_DATA} ffdc_state_e;
endpackage

//--- rtl/ffdc_top.sv
// frame fetch dma control: registers, fetch sequencer, input fifo, interrupt
`timescale 1ns/100ps
module ffdc_top import ffdc_pkg::*; #(
    parameter bit HAS_THRESHOLD = 1'b1  // zero for reduced variants
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // memory read port
    output logic             mem_req,
    output logic      [31:0] mem_addr,
    output logic      [4:0]  mem_len,
    output logic      [1:0]  mem_size,
    input  wire logic        mem_ack,
    input  wire logic        mem_rvalid,
    input  wire logic [31:0] mem_rdata,
    // raster side
    output logic             fifo_ready,
    output logic             pix_valid,
    output logic      [31:0] pix_data,
    input  wire logic        pix_take,
    // interrupt
    output logic             irq
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // threshold decode table
    function automatic logic [9:0] thr_words(input logic [2:0] code);
        // reserved code 7 is treated as the largest threshold
        thr_words = (code == 3'h7) ? 10'h200 : 10'(10'h008 << code);
    endfunction
    function automatic logic [4:0] burst_words(input logic [2:0] code);
        // reserved codes fall back to single transfers
        burst_words = (code > 3'h4) ? 5'h01 : 5'(5'h01 << code);
    endfunction
    function automatic logic [31:0] bswap(input logic [31:0] w);
        bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;                    // control word
    logic [31:0] base_q [2];                // buffer start addresses
    logic [31:0] ceil_q [2];                // buffer ending addresses
    logic [1:0]  stat_q;                    // sticky frame-end flags
    logic [1:0]  mask_q;                    // frame-end mask
    logic        run_q;                     // fetch enabled
    logic [1:0]  frame_end;                 // one-cycle frame-end events
    logic [31:0] ctrl_wmask;                // writable control bits
    logic        stat_rd;                   // status read clears

    // threshold bits held reserved on reduced builds
    assign ctrl_wmask = HAS_THRESHOLD ? FFDC_CTRL_WMASK : (FFDC_CTRL_WMASK & 32'hFFFF_F8FF);
    assign stat_rd    = reg_rd && (reg_addr == FFDC_STAT_OFS);

    // control and run registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q <= FFDC_CTRL_RST;
            run_q  <= 1'b0;
            mask_q <= 2'h0;
        end else if (reg_wr) begin
            if (reg_addr == FFDC_CTRL_OFS) ctrl_q <= reg_wdata & ctrl_wmask;
            if (reg_addr == FFDC_RUN_OFS)  run_q  <= reg_wdata[0];
            if (reg_addr == FFDC_MASK_OFS) mask_q <= reg_wdata[1:0];
        end
    end

    // address registers, one pair per buffer
    generate
        for (genvar b = 0; b < 2; b++) begin : g_buf
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    base_q[b] <= 32'h0000_0000;
                    ceil_q[b] <= 32'h0000_0000;
                end else if (reg_wr) begin
                    if (reg_addr == (b ? FFDC_B_BASE_OFS : FFDC_A_BASE_OFS))
                        base_q[b] <= reg_wdata & FFDC_ADDR_MASK;
                    if (reg_addr == (b ? FFDC_B_CEIL_OFS : FFDC_A_CEIL_OFS))
                        ceil_q[b] <= reg_wdata & FFDC_ADDR_MASK;
                end
            end
        end
    endgenerate

    // sticky status: a new event wins over the clearing read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stat_q <= 2'h0;
        end else begin
            stat_q <= (stat_rd ? 2'h0 : stat_q) | frame_end;
        end
    end

    // read data, one cycle after the strobe and only then
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                FFDC_CTRL_OFS:   reg_rdata <= ctrl_q;
                FFDC_A_BASE_OFS: reg_rdata <= base_q[0];
                FFDC_A_CEIL_OFS: reg_rdata <= ceil_q[0];
                FFDC_B_BASE_OFS: reg_rdata <= base_q[1];
                FFDC_B_CEIL_OFS: reg_rdata <= ceil_q[1];
                FFDC_STAT_OFS:   reg_rdata <= {30'h0, stat_q};
                FFDC_MASK_OFS:   reg_rdata <= {30'h0, mask_q};
                FFDC_RUN_OFS:    reg_rdata <= {31'h0, run_q};
                default:         reg_rdata <= 32'h0000_0000;  // unmapped
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // enable bit gates both buffer flags
    assign irq = ctrl_q[FFDC_IRQEN_BIT] && |(stat_q & mask_q);

    // ------------------------------------------------------------
    // input fifo
    // ------------------------------------------------------------
    logic [31:0]           fifo_mem [FFDC_DEPTH];  // pixel words
    logic [FFDC_PTR_W-1:0] wr_ptr_q;               // write pointer
    logic [FFDC_PTR_W-1:0] rd_ptr_q;               // read pointer
    logic [9:0]            count_q;                // words held
    logic [9:0]            loaded_q;               // words loaded since start
    logic                  fifo_wr;                // word arriving
    logic                  fifo_rd;                // word leaving
    logic [31:0]           wr_word;                // word after reordering
    logic [9:0]            thresh;                 // words needed for ready

    assign fifo_wr = mem_rvalid;
    assign fifo_rd = pix_valid && pix_take;
    assign wr_word = ctrl_q[FFDC_SWAP_BIT] ? bswap(mem_rdata) : mem_rdata;
    // reduced builds use the smallest threshold
    assign thresh  = HAS_THRESHOLD ? thr_words(ctrl_q[FFDC_THR_LO +: 3]) : thr_words(3'h0);

    // storage array, no reset needed on data
    always_ff @(posedge mclk) begin
        if (fifo_wr) fifo_mem[wr_ptr_q] <= wr_word;
    end

    // pointers and occupancy
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= 10'h000;
        end else if (!run_q) begin
            // stopping flushes stale pixels
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= 10'h000;
        end else begin
            if (fifo_wr) wr_ptr_q <= wr_ptr_q + 1'b1;
            if (fifo_rd) rd_ptr_q <= rd_ptr_q + 1'b1;
            count_q <= 10'(count_q + {9'h0, fifo_wr} - {9'h0, fifo_rd});
        end
    end

    // ready held low until threshold reached
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            loaded_q   <= 10'h000;
            fifo_ready <= 1'b0;
        end else if (!run_q) begin
            loaded_q   <= 10'h000;
            fifo_ready <= 1'b0;
        end else begin
            if (fifo_wr && loaded_q != FFDC_DEPTH_C) loaded_q <= loaded_q + 10'h001;
            if (loaded_q >= thresh) fifo_ready <= 1'b1;
        end
    end

    assign pix_valid = fifo_ready && (count_q != 10'h000);
    assign pix_data  = fifo_mem[rd_ptr_q];

    // ------------------------------------------------------------
    // fetch sequencer
    // ------------------------------------------------------------
    ffdc_state_e state_q;      // sequencer state
    logic        sel_q;        // buffer being fetched
    logic [31:0] addr_q;       // next word address
    logic [4:0]  beats_q;      // beats left in burst
    logic [4:0]  len_d;        // length of next burst
    logic [31:0] left_words;   // words left in frame, minus one

    assign left_words = (ceil_q[sel_q] - addr_q) >> 2;
    // shorten the last burst of a frame
    always_comb begin
        len_d = burst_words(ctrl_q[FFDC_BURST_LO +: 3]);
        if (left_words < 32'({27'h0, len_d}) - 32'h1) len_d = 5'(left_words + 32'h1);
    end

    // sequencer: issue, collect beats, close frames
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q   <= FFDC_IDLE;
            sel_q     <= 1'b0;
            addr_q    <= 32'h0000_0000;
            beats_q   <= 5'h00;
            mem_len   <= 5'h00;
            frame_end <= 2'h0;
        end else begin
            frame_end <= 2'h0;
            case (state_q)
                FFDC_IDLE: begin
                    if (!run_q) begin
                        sel_q  <= 1'b0;
                        addr_q <= base_q[0];
                    // wait until the whole burst fits in the fifo
                    end else if (32'(count_q) + 32'(len_d) <= 32'(FFDC_DEPTH_C)) begin
                        mem_len <= len_d;
                        state_q <= FFDC_REQ;
                    end
                end
                FFDC_REQ: begin
                    if (mem_ack) begin
                        beats_q <= mem_len;
                        state_q <= FFDC_DATA;
                    end
                end
                FFDC_DATA: begin
                    if (mem_rvalid) begin
                        beats_q <= beats_q - 5'h01;
                        addr_q  <= addr_q + FFDC_WORD_BYTES;
                        if (beats_q == 5'h01) begin
                            state_q <= FFDC_IDLE;
                            if (addr_q >= ceil_q[sel_q]) begin
                                frame_end[sel_q] <= 1'b1;
                                sel_q  <= ctrl_q[FFDC_MODE_BIT] ? ~sel_q : 1'b0;
                                addr_q <= base_q[ctrl_q[FFDC_MODE_BIT] ? ~sel_q : 1'b0];
                            end
                        end
                    end
                end
                default: state_q <= FFDC_IDLE;
            endcase
        end
    end

    assign mem_req  = (state_q == FFDC_REQ);
    assign mem_addr = addr_q & FFDC_ADDR_MASK;
    assign mem_size = FFDC_SIZE_WORD;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    ready_gate_a: assert property ($rose(fifo_ready) |-> loaded_q >= thresh && loaded_q != 10'h000)
        else $error("fifo ready before threshold");
    thresh_map_a: assert property (HAS_THRESHOLD && ctrl_q[10:8] == 3'h6 |-> thresh == 10'h200)
        else $error("threshold decode wrong");
    burst_map_a: assert property (mem_req && ctrl_q[6:4] == 3'h4 && left_words >= 32'hF |-> mem_len == 5'h10)
        else $error("burst decode wrong");
    word_size_a: assert property (mem_req |-> mem_size == 2'h2)
        else $error("fetch not a word");
    irq_gate_a: assert property (!ctrl_q[2] |-> !irq)
        else $error("interrupt while disabled");
    irq_raise_a: assert property (ctrl_q[2] && |(frame_end & mask_q) |=> irq)
        else $error("interrupt not raised");
    thr_absent_a: assert property (!HAS_THRESHOLD && reg_rd && reg_addr == FFDC_CTRL_OFS |=> reg_rdata[10:8] == 3'h0)
        else $error("reduced threshold field visible");
    single_buf_a: assert property (!ctrl_q[0] && $past(!ctrl_q[0]) && mem_req |-> !sel_q)
        else $error("second buffer in single mode");
    swap_order_a: assert property (fifo_wr && ctrl_q[1] |-> wr_word[7:0] == mem_rdata[31:24])
        else $error("bytes not reordered");
    addr_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
        else $error("fetch address misaligned");

    frame_a_c: cover property (frame_end[0]);
    frame_b_c: cover property (frame_end[1] ##[1:1000] frame_end[0]);
    ready_c:   cover property ($rose(fifo_ready) ##1 fifo_rd);
endmodule

//--- tb/ffdc_mem_model.sv
// memory responder model standing in for the system bus at the fetch port
`timescale 1ns/100ps
module ffdc_mem_model (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // burst request from the fetch sequencer
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic [4:0]  mem_len,
    // answer towards the fetch sequencer
    output logic             mem_ack,
    output logic             mem_rvalid,
    output logic      [31:0] mem_rdata,
    // burst still in flight
    output logic             busy
);
    integer      seed = 9;  // own stream, apart from the bench
    logic [31:0] addr_q;    // byte address of the next beat
    logic [4:0]  left_q;    // beats still owed
    // stored word: four distinct bytes unless a[9:2] is 0x66 or 0xE6, so any reordering shows
    function automatic logic [31:0] pat(input logic [31:0] a);
        pat = {a[9:2] ^ 8'h5A, a[9:2], ~a[9:2], a[9:2] + 8'h33};
    endfunction
    assign busy = (left_q != 5'h00) || mem_ack;
    // accept promptly or slowly, then stream beats with random gaps
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_ack    <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= 32'h0000_0000;
            addr_q     <= 32'h0000_0000;
            left_q     <= 5'h00;
        end else begin
            mem_ack    <= 1'b0;
            mem_rvalid <= 1'b0;
            // idle data lines toggle so a stale word is never mistaken for a beat
            mem_rdata  <= ~mem_rdata;
            if (left_q == 5'h00 && mem_req && !mem_ack && ($random(seed) & 1)) begin
                mem_ack <= 1'b1;
                addr_q  <= mem_addr;
                left_q  <= mem_len;
            end else if (left_q != 5'h00 && !mem_ack && ($random(seed) & 1)) begin
                mem_rvalid <= 1'b1;
                mem_rdata  <= pat(addr_q);
                addr_q     <= addr_q + 32'h0000_0004;
                left_q     <= left_q - 5'h01;
            end
        end
    end
endmodule

//--- tb/frame_fetch_dma_control_bench.sv
// self-checking bench for the frame fetch dma control block
`timescale 1ns/100ps
module frame_fetch_dma_control_bench import ffdc_pkg::*;;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pix_take = 0;
    logic [4:0]  reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata, mem_addr, mem_rdata, pix_data, v, nxt, ce, ba;
    logic [31:0] base_a, ceil_a, base_b, ceil_b;
    logic [31:0] red_rdata, red_v;  // read data of the reduced build
    logic        red_req;           // reduced build request, looped back as its own ack
    logic [4:0]  mem_len;
    logic [1:0]  mem_size;
    logic [2:0]  kc, t;
    logic        mem_req, mem_ack, mem_rvalid, fifo_ready, pix_valid, irq, busy;
    logic        use_b, mode, swap, en, took_irq, popping = 0;
    integer      seed = 35131, miscompares = 0, checked = 0;
    int          loaded, thr, bl, late, pops, rem, n, idle;
    logic [31:0] aq[$];     // byte addresses of words now in the fifo
    always #10 mclk = ~mclk;
    ffdc_top dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_addr(mem_addr), .mem_len(mem_len),
        .mem_size(mem_size), .mem_ack(mem_ack), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .fifo_ready(fifo_ready), .pix_valid(pix_valid), .pix_data(pix_data), .pix_take(pix_take), .irq(irq));
    ffdc_mem_model mem_u (.mclk(mclk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr), .mem_len(mem_len),
        .mem_ack(mem_ack), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .busy(busy));
    // reduced build shares the register port; it never gets beats, so it parks after one request
    ffdc_top #(.HAS_THRESHOLD(1'b0)) dut_r (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(red_rdata), .mem_req(red_req), .mem_addr(), .mem_len(),
        .mem_size(), .mem_ack(red_req), .mem_rvalid(1'b0), .mem_rdata(32'h0000_0000), .fifo_ready(),
        .pix_valid(), .pix_data(), .pix_take(1'b0), .irq());
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        if (miscompares == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task hang;  // a bound ran out
        miscompares++;
        results();
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
        red_v = red_rdata;
    endtask
    // expected fifo word, byte order reversed when swapping
    function automatic logic [31:0] want(input logic [31:0] a);
        want = mem_u.pat(a);
        if (swap) want = {want[7:0], want[15:8], want[23:16], want[31:24]};
    endfunction
    // ------------------------------------------------------------
    // monitor of the fetch port and the raster side
    // ------------------------------------------------------------
    always @(posedge mclk) if (!rst) begin
        pix_take <= popping && (($random(seed) & 3) != 0);
        if (mem_req && mem_ack) begin
            ce  = use_b ? ceil_b : ceil_a;
            rem = (ce - nxt) / 4 + 1;
            rem = rem < bl ? rem : bl;
            check(mem_addr, nxt);
            check(32'(mem_len), 32'(rem));
            check(32'(mem_size), 32'(FFDC_SIZE_WORD));
            ba  = mem_addr;
            nxt = nxt + 32'(4 * rem);
            // past the ceiling: frame done, pick the next buffer
            if (nxt > ce) begin
                use_b = mode & ~use_b;
                nxt   = use_b ? base_b : base_a;
            end
        end
        if (mem_rvalid) begin
            aq.push_back(ba);
            ba = ba + 32'h0000_0004;
            loaded++;
        end
        if (pix_valid && pix_take) begin
            check(pix_data, want(aq.pop_front()));
            pops++;
        end
        if (fifo_ready && loaded < thr) check(32'(loaded), 32'(thr));
        // only while a scenario runs: between scenarios the fifo is stopped and ready is low
        late = (popping && loaded >= thr && !fifo_ready) ? late + 1 : 0;
        if (late == 3) check(32'(fifo_ready), 32'h0000_0001);
        if (irq && !en) check(32'(irq), 32'h0000_0000);
        took_irq = took_irq | irq;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd(FFDC_CTRL_OFS, v); check(v, FFDC_CTRL_RST);
        wr(FFDC_CTRL_OFS, 32'hFFFF_FFFF); rd(FFDC_CTRL_OFS, v); check(v, FFDC_CTRL_WMASK);
        check(red_v, 32'h0000_0077);
        wr(FFDC_B_CEIL_OFS, 32'h0000_2007); rd(FFDC_B_CEIL_OFS, v); check(v, 32'h0000_2004);
        wr(FFDC_MASK_OFS, 32'h0000_0003);
        // every burst code once, threshold codes at random
        for (int k = 0; k < 8; k++) begin
            kc   = 3'(k);
            mode = kc[0];
            swap = kc[1];
            en   = (k != 5);
            bl   = k <= 4 ? 1 << k : 1;
            t    = 3'($random(seed));
            // shortened bursts in double mode could stall a full fifo short of 512
            if (mode && t > 3'h5) t = 3'h5;
            thr    = t <= 3'h6 ? 8 << t : 512;
            base_a = 32'h0000_1000 + 32'(k << 12);
            ceil_a = base_a + 32'(64 * (2 + ($random(seed) & 1))) - 32'h0000_0004;
            base_b = base_a + 32'h0000_0800;
            ceil_b = base_b + 32'h0000_0018;
            wr(FFDC_A_BASE_OFS, base_a); wr(FFDC_A_CEIL_OFS, ceil_a);
            wr(FFDC_B_BASE_OFS, base_b); wr(FFDC_B_CEIL_OFS, ceil_b);
            wr(FFDC_CTRL_OFS, {21'h0, t, 1'b0, kc, 1'b0, en, swap, mode});
            nxt = base_a; use_b = 0; loaded = 0; late = 0; pops = 0; took_irq = 0;
            aq.delete();
            wr(FFDC_RUN_OFS, 32'h0000_0001);
            popping = 1;
            for (n = 0; n < 30000 && pops < 700; n++) @(posedge mclk);
            if (pops < 700) hang();
            popping = 0;
            if (en) check(32'(took_irq), 32'h0000_0001);
            // let the fifo fill so no burst is left in flight
            idle = 0;
            for (n = 0; n < 4000 && idle < 40; n++) begin
                @(posedge mclk);
                idle = (mem_req || busy) ? 0 : idle + 1;
            end
            if (idle < 40) hang();
            wr(FFDC_RUN_OFS, 32'h0000_0000);
            rd(FFDC_STAT_OFS, v); check(v, {30'h0, mode, 1'b1});
            rd(FFDC_STAT_OFS, v); check(v, 32'h0000_0000);
            check(32'(irq), 32'h0000_0000);
            check(32'(fifo_ready), 32'h0000_0000);
        end
        results();
    end
endmodule
